// ===== bench/lfd_regs_props.sv
// Checker for the LED fault and diagnostic register bank
`timescale 1ns/1ps
module lfd_regs_props
  import lfd_pkg::*;
(
  input wire logic                  sys_clk,            // Clock
  input wire logic                  rst_n,              // Reset
  input wire logic [LFD_ADDR_W-1:0] avs_address,        // Address
  input wire logic                  avs_read,           // Read
  input wire logic                  avs_write,          // Write
  input wire logic [31:0]           avs_writedata,      // Wdata
  input wire logic [3:0]            avs_byteenable,     // Byte enables
  input wire logic [31:0]           avs_readdata,       // Rdata
  input wire logic                  avs_waitrequest,    // Stall
  input wire logic [1:0]            avs_response,       // Response
  input wire logic                  bus_timeout_evt,    // Event
  input wire logic                  bad_string_cfg_evt, // Event
  input wire logic                  ground_short_evt,   // Event
  input wire logic                  internal_short_evt, // Event
  input wire logic                  open_circuit_evt,   // Event
  input wire logic [LFD_NUM_CH-1:0] channel_fault_in,   // Channels
  input wire logic [4:0]            live_state_code,    // State
  input wire logic [15:0]           dim_in_duty,        // Duty in
  input wire logic [15:0]           dim_out_duty,       // Duty out
  input wire logic                  irq                 // Interrupt
);
  logic       rd_ok;
  logic       wr_ok;
  logic       evt;
  logic [7:0] idx;
  logic       mapped;
  assign rd_ok = avs_read && !avs_waitrequest;
  assign wr_ok = avs_write && !avs_waitrequest;
  assign evt = bus_timeout_evt | bad_string_cfg_evt | ground_short_evt | internal_short_evt | open_circuit_evt;
  assign idx = avs_address[9:2];
  assign mapped = idx inside {8'h12, 8'h14, 8'h16, 8'h18, 8'h20, 8'h21, 8'h22};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request waited more than one cycle");
  AST_IDLE_NOWAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("stall raised while idle");
  AST_UNMAPPED: assert property (rd_ok && !mapped |-> avs_response == 2'b10 && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
  AST_MAPPED_OK: assert property (rd_ok && mapped |-> avs_response == 2'b00 && avs_readdata[31:16] == 16'h0)
    else $error("mapped read bad response or upper half");
  AST_STATE_WORD: assert property (rd_ok && idx == 8'h14 |-> avs_readdata[15:0] == {11'h0, $past(live_state_code, 2)})
    else $error("state readout wrong");
  AST_DIM_IN: assert property (rd_ok && idx == 8'h16 |-> avs_readdata[15:0] == $past(dim_in_duty, 2))
    else $error("input duty readout wrong");
  AST_DIM_OUT: assert property (rd_ok && idx == 8'h18 |-> avs_readdata[15:0] == $past(dim_out_duty, 2))
    else $error("output duty readout wrong");
  AST_IRQ_MASK: assert property (wr_ok && idx == 8'h21 && avs_byteenable[0] && avs_writedata[2:0] == 3'h0 |=> !irq)
    else $error("masked interrupt still high");
  AST_IRQ_CLEAR: assert property (wr_ok && idx == 8'h22 && avs_byteenable[0] && avs_writedata[2:0] == 3'h7 && !evt
    |=> !irq)
    else $error("cleared interrupt still high");
endmodule : lfd_regs_props

bind lfd_regs lfd_regs_props lfd_regs_props_inst (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .bus_timeout_evt,
  .bad_string_cfg_evt, .ground_short_evt, .internal_short_evt, .open_circuit_evt, .channel_fault_in,
  .live_state_code, .dim_in_duty, .dim_out_duty, .irq);

// ===== bench/test_lfd_regs.sv
// Self-checking bench for the LED fault and diagnostic register bank
`timescale 1ns/1ps
module test_lfd_regs;
  import lfd_pkg::*;
  logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0]  avs_response;
  logic [3:0]  be;
  logic [4:0]  ev, st;
  logic [5:0]  ch;
  logic [15:0] din, dout;
  int          n_mismatch = 0, n_checks = 0, cyc = 0;
  int          sb [5] = '{14, 12, 10, 10, 10};
  int          sub [5] = '{0, 0, 8, 7, 6};
  logic [7:0]  ra [7] = '{8'h12, 8'h14, 8'h16, 8'h18, 8'h20, 8'h21, 8'h22};

  lfd_regs lfd_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .bus_timeout_evt(ev[0]),
    .bad_string_cfg_evt(ev[1]), .ground_short_evt(ev[2]), .internal_short_evt(ev[3]),
    .open_circuit_evt(ev[4]), .channel_fault_in(ch), .live_state_code(st), .dim_in_duty(din),
    .dim_out_duty(dout), .irq(irq));

  function automatic logic [15:0] fexp(int k);
    return (16'h1 << sb[k]) | (k > 1 ? 16'h1 << sub[k] : 16'h0);
  endfunction : fexp

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until the edge that sees the stall low
  task automatic acc(input logic w, input logic [7:0] i, input logic [15:0] d);
    @(posedge sys_clk);
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0, d};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc

  task automatic rd(input logic [7:0] i, input logic [15:0] e);
    acc(1'b0, i, 16'h0);
    chk(q, {16'h0, e});
  endtask : rd

  // Irq is settled only after the accepting edge has landed
  task automatic ci(input logic e);
    @(negedge sys_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : ci

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(32'h7b68ab36));
    {rst_n, avs_read, avs_write, avs_address, avs_writedata, ev, st, ch, din, dout} = '0;
    be = 4'hf;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (ra[j]) rd(ra[j], 16'h0);
    for (int j = 0; j < 12; j++) begin
      @(posedge sys_clk);
      ch <= 6'($urandom);
      st <= (j == 0) ? 5'h13 : 5'($urandom_range(19));
      din <= (j == 0) ? 16'hffff : 16'($urandom);
      dout <= 16'($urandom);
      repeat (4) @(posedge sys_clk);
      rd(8'h12, {10'h0, ch});
      rd(8'h14, {11'h0, st});
      rd(8'h16, din);
      rd(8'h18, dout);
    end
    ch <= 6'h0;
    acc(1'b1, 8'h14, 16'hffff);
    rd(8'h14, {11'h0, st});
    acc(1'b0, 8'h13, 16'h0);
    chk({avs_response, q[29:0]}, 32'h80000000);
    acc(1'b1, 8'h21, 16'h7);
    for (int k = 0; k < 5; k++) begin
      @(posedge sys_clk);
      ev <= 5'h1 << k;
      @(posedge sys_clk);
      ev <= 5'h0;
      rd(8'h12, fexp(k));
      rd(8'h20, 16'h1 << (k > 1 ? 2 : k));
      ci(1'b1);
      acc(1'b1, 8'h12, 16'h1 << sb[k]);
      acc(1'b1, 8'h12, 16'h1 << (sb[k] - 1));
      rd(8'h12, fexp(k));
      acc(1'b1, 8'h21, 16'h0);
      ci(1'b0);
      acc(1'b1, 8'h21, 16'h7);
      ci(1'b1);
      acc(1'b1, 8'h12, 16'h3 << (sb[k] - 1));
      ci(1'b0);
      rd(8'h12, 16'h0);
    end
    @(posedge sys_clk);
    ev <= 5'h1f;
    @(posedge sys_clk);
    ev <= 5'h0;
    ci(1'b1);
    // A pair clear missing the upper byte enable must be refused
    be <= 4'h1;
    acc(1'b1, 8'h12, 16'h7e00);
    be <= 4'hf;
    rd(8'h12, 16'h55c0);
    ci(1'b1);
    acc(1'b1, 8'h22, 16'h7);
    ci(1'b0);
    rd(8'h20, 16'h0);
    rd(8'h12, 16'h55c0);
    tally_and_finish();
  end
endmodule : test_lfd_regs

// ===== core/lfd_pkg.sv
// Package for the LED fault and diagnostic register bank
package lfd_pkg;
  // Register offsets as printed (all multiples of two except 8'h21; word index = offset, byte address = 4*index)
  localparam logic [7:0] LFD_IDX_LED_FAULT_STATUS   = 8'h12;
  localparam logic [7:0] LFD_IDX_STATE_READOUT      = 8'h14;
  localparam logic [7:0] LFD_IDX_DIM_IN_DUTY        = 8'h16;
  localparam logic [7:0] LFD_IDX_DIM_OUT_DUTY       = 8'h18;
  localparam logic [7:0] LFD_IDX_IRQ_STATUS         = 8'h20;
  localparam logic [7:0] LFD_IDX_IRQ_ENABLE         = 8'h21;
  localparam logic [7:0] LFD_IDX_IRQ_CLEAR          = 8'h22;
  localparam int         LFD_ADDR_W                 = 10;
  localparam int         LFD_IDX_LSB                = 2;

  localparam int LFD_REG_W = 16;
  // Field positions inside the LED fault word
  localparam int LFD_BIT_BUS_TMO      = 14;
  localparam int LFD_BIT_BUS_TMO_CLR  = 13;
  localparam int LFD_BIT_BAD_STR      = 12;
  localparam int LFD_BIT_BAD_STR_CLR  = 11;
  localparam int LFD_BIT_SUMMARY      = 10;
  localparam int LFD_BIT_SUMMARY_CLR  = 9;
  localparam int LFD_BIT_GND_SHORT    = 8;
  localparam int LFD_BIT_INT_SHORT    = 7;
  localparam int LFD_BIT_OPEN         = 6;
  localparam int LFD_NUM_CH           = 6;
  localparam int LFD_STATE_W          = 5;
  localparam logic [15:0] LFD_RESET_VAL = 16'h0000;

  // Interrupt event bits
  localparam int LFD_IRQ_W        = 3;
  localparam int LFD_IRQ_BUS_TMO  = 0;
  localparam int LFD_IRQ_BAD_STR  = 1;
  localparam int LFD_IRQ_SUMMARY  = 2;

  // Functional state codes shown in the state readout
  typedef enum logic [4:0] {
    LFD_ST_DISABLED   = 5'h00,
    LFD_ST_REG_START  = 5'h01,
    LFD_ST_MEM_READ   = 5'h02,
    LFD_ST_STANDBY    = 5'h03,
    LFD_ST_CONV_START = 5'h04,
    LFD_ST_NORMAL     = 5'h10,
    LFD_ST_SHUTDOWN   = 5'h11,
    LFD_ST_RECOVERY   = 5'h12,
    LFD_ST_ALL_FAULT  = 5'h13
  } lfd_state_t;

  // Bus slave states, Gray along idle -> answer
  typedef enum logic [1:0] {
    LFD_BUS_IDLE = 2'b00,
    LFD_BUS_ACK  = 2'b01
  } lfd_bus_t;
endpackage : lfd_pkg

// ===== core/lfd_regs.sv
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// LED fault status and diagnostic readout registers with Avalon-MM slave
module lfd_regs
  import lfd_pkg::*;
(
  input  wire logic                  sys_clk,            // 25 MHz system clock
  input  wire logic                  rst_n,              // Asynchronous reset, active low
  input  wire logic [LFD_ADDR_W-1:0] avs_address,        // Byte address
  input  wire logic                  avs_read,           // Read request
  input  wire logic                  avs_write,          // Write request
  input  wire logic [31:0]           avs_writedata,      // Write data
  input  wire logic [3:0]            avs_byteenable,     // Byte enables
  output logic      [31:0]           avs_readdata,       // Read data
  output logic                       avs_waitrequest,    // Stall
  output logic      [1:0]            avs_response,       // 00 ok, 10 slave error
  input  wire logic                  bus_timeout_evt,    // Host bus timeout pulse
  input  wire logic                  bad_string_cfg_evt, // Invalid string configuration pulse
  input  wire logic                  ground_short_evt,   // Short to ground detected
  input  wire logic                  internal_short_evt, // Internal short detected
  input  wire logic                  open_circuit_evt,   // Open circuit detected
  input  wire logic [LFD_NUM_CH-1:0] channel_fault_in,   // Live per-channel fault, bit0 = channel one
  input  wire logic [4:0]            live_state_code,    // Functional state machine code
  input  wire logic [15:0]           dim_in_duty,        // Measured dimming input duty
  input  wire logic [15:0]           dim_out_duty,       // Configured dimming output duty
  output logic                       irq                 // Level interrupt
);
  lfd_bus_t                 bus_st;
  logic                     bad_string_cfg_flag;
  logic                     bus_timeout_flag;
  logic                     led_fault_summary;
  logic                     ground_short_flag;
  logic                     internal_short_flag;
  logic                     open_circuit_flag;
  logic [LFD_NUM_CH-1:0]    chan_fault;
  logic [4:0]               state_q;
  logic [15:0]              dim_in_q;
  logic [15:0]              dim_out_q;
  logic [LFD_IRQ_W-1:0]     irq_status;
  logic [LFD_IRQ_W-1:0]     irq_enable;
  logic [LFD_IRQ_W-1:0]     irq_evt;
  logic [LFD_IRQ_W-1:0]     irq_clr;
  logic [7:0]               idx;
  logic                     wr_acc;
  logic                     lo_be;
  logic [15:0]              wdat;
  logic                     clr_tmo;
  logic                     clr_str;
  logic                     clr_sum;
  logic [31:0]              next_readdata;
  logic                     next_err;

  function automatic logic lfd_mapped(input logic [7:0] i);
    return (i == LFD_IDX_LED_FAULT_STATUS) || (i == LFD_IDX_STATE_READOUT) ||
           (i == LFD_IDX_DIM_IN_DUTY) || (i == LFD_IDX_DIM_OUT_DUTY) ||
           (i == LFD_IDX_IRQ_STATUS) || (i == LFD_IDX_IRQ_ENABLE) || (i == LFD_IDX_IRQ_CLEAR);
  endfunction : lfd_mapped

  // Fields take effect only when both status and clear bits are written as one
  function automatic logic lfd_pair(input logic [15:0] d, input int s, input int c);
    return d[s] & d[c];
  endfunction : lfd_pair

  assign idx   = 8'(avs_address[LFD_ADDR_W-1:LFD_IDX_LSB]);
  assign lo_be = avs_byteenable[0] & avs_byteenable[1];
  assign wdat  = avs_writedata[15:0];
  // Write takes effect at the accepting edge only
  assign wr_acc = (bus_st == LFD_BUS_ACK) && avs_write;

  assign clr_tmo = wr_acc && lo_be && idx == LFD_IDX_LED_FAULT_STATUS &&
                   lfd_pair(wdat, LFD_BIT_BUS_TMO, LFD_BIT_BUS_TMO_CLR);
  assign clr_str = wr_acc && lo_be && idx == LFD_IDX_LED_FAULT_STATUS &&
                   lfd_pair(wdat, LFD_BIT_BAD_STR, LFD_BIT_BAD_STR_CLR);
  assign clr_sum = wr_acc && lo_be && idx == LFD_IDX_LED_FAULT_STATUS &&
                   lfd_pair(wdat, LFD_BIT_SUMMARY, LFD_BIT_SUMMARY_CLR);

  // One wait cycle: request seen, answered at the next edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_st <= LFD_BUS_IDLE;
    end else begin
      case (bus_st)
        LFD_BUS_IDLE: bus_st <= (avs_read || avs_write) ? LFD_BUS_ACK : LFD_BUS_IDLE;
        LFD_BUS_ACK:  bus_st <= LFD_BUS_IDLE;
        default:      bus_st <= LFD_BUS_IDLE;
      endcase
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && (bus_st != LFD_BUS_ACK);

  lfd_sticky u_tmo (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .set_evt (bus_timeout_evt),
    .clr_req (clr_tmo),
    .flag    (bus_timeout_flag)
  );

  lfd_sticky u_str (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .set_evt (bad_string_cfg_evt),
    .clr_req (clr_str),
    .flag    (bad_string_cfg_flag)
  );

  lfd_sticky u_sum (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .set_evt (ground_short_evt | internal_short_evt | open_circuit_evt),
    .clr_req (clr_sum),
    .flag    (led_fault_summary)
  );

  // Sub-flags have no clear of their own; they go with the summary flag
  lfd_sticky u_gnd (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .set_evt (ground_short_evt),
    .clr_req (clr_sum),
    .flag    (ground_short_flag)
  );

  lfd_sticky u_ish (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .set_evt (internal_short_evt),
    .clr_req (clr_sum),
    .flag    (internal_short_flag)
  );

  lfd_sticky u_opn (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .set_evt (open_circuit_evt),
    .clr_req (clr_sum),
    .flag    (open_circuit_flag)
  );

  // Live readouts registered so read data never glitches mid-answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_fault <= '0;
      state_q    <= LFD_ST_DISABLED;
      dim_in_q   <= LFD_RESET_VAL;
      dim_out_q  <= LFD_RESET_VAL;
    end else begin
      chan_fault <= channel_fault_in;
      state_q    <= live_state_code;
      dim_in_q   <= dim_in_duty;
      dim_out_q  <= dim_out_duty;
    end
  end

  // Interrupt: sticky events, enable mask, write-one-to-clear register
  assign irq_evt[LFD_IRQ_BUS_TMO] = bus_timeout_evt;
  assign irq_evt[LFD_IRQ_BAD_STR] = bad_string_cfg_evt;
  assign irq_evt[LFD_IRQ_SUMMARY] = ground_short_evt | internal_short_evt | open_circuit_evt;

  always_comb begin
    irq_clr = '0;
    if (wr_acc && avs_byteenable[0] && idx == LFD_IDX_IRQ_CLEAR) begin
      irq_clr = wdat[LFD_IRQ_W-1:0];
    end
    // Paired fault-word clear also drops the pin status
    irq_clr[LFD_IRQ_BUS_TMO] = irq_clr[LFD_IRQ_BUS_TMO] | clr_tmo;
    irq_clr[LFD_IRQ_BAD_STR] = irq_clr[LFD_IRQ_BAD_STR] | clr_str;
    irq_clr[LFD_IRQ_SUMMARY] = irq_clr[LFD_IRQ_SUMMARY] | clr_sum;
  end

  genvar g;
  generate
    for (g = 0; g < LFD_IRQ_W; g++) begin : g_irq
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          irq_status[g] <= 1'b0;
        end else if (irq_evt[g]) begin
          irq_status[g] <= 1'b1;
        end else if (irq_clr[g]) begin
          irq_status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable <= '0;
    end else if (wr_acc && avs_byteenable[0] && idx == LFD_IDX_IRQ_ENABLE) begin
      irq_enable <= wdat[LFD_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_enable);

  always_comb begin
    next_readdata = 32'h0000_0000;
    next_err      = !lfd_mapped(idx);
    case (idx)
      LFD_IDX_LED_FAULT_STATUS: begin
        next_readdata[LFD_BIT_BUS_TMO]   = bus_timeout_flag;
        next_readdata[LFD_BIT_BAD_STR]   = bad_string_cfg_flag;
        next_readdata[LFD_BIT_SUMMARY]   = led_fault_summary;
        next_readdata[LFD_BIT_GND_SHORT] = ground_short_flag;
        next_readdata[LFD_BIT_INT_SHORT] = internal_short_flag;
        next_readdata[LFD_BIT_OPEN]      = open_circuit_flag;
        next_readdata[LFD_NUM_CH-1:0]    = chan_fault;
      end
      LFD_IDX_STATE_READOUT: next_readdata[LFD_STATE_W-1:0] = state_q;
      LFD_IDX_DIM_IN_DUTY:   next_readdata[LFD_REG_W-1:0]   = dim_in_q;
      LFD_IDX_DIM_OUT_DUTY:  next_readdata[LFD_REG_W-1:0]   = dim_out_q;
      LFD_IDX_IRQ_STATUS:    next_readdata[LFD_IRQ_W-1:0]   = irq_status;
      LFD_IDX_IRQ_ENABLE:    next_readdata[LFD_IRQ_W-1:0]   = irq_enable;
      default:               next_readdata = 32'h0000_0000;
    endcase
  end

  // Read data registered in the wait cycle; it stands at the accepting edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end else if (bus_st == LFD_BUS_IDLE && (avs_read || avs_write)) begin
      avs_readdata <= avs_read ? next_readdata : 32'h0000_0000;
      avs_response <= next_err ? 2'b10 : 2'b00;
    end
  end
endmodule : lfd_regs

// ===== core/lfd_sticky.sv
`timescale 1ns/1ps
// Sticky fault flag cleared by a status-plus-clear write; set wins over clear
module lfd_sticky
  import lfd_pkg::*;
(
  input  wire logic sys_clk,   // System clock
  input  wire logic rst_n,     // Asynchronous reset, active low
  input  wire logic set_evt,   // Raw fault event, same clock
  input  wire logic clr_req,   // Paired status and clear written as ones
  output logic      flag       // Latched fault
);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clr_req) begin
      flag <= 1'b0;
    end
  end
endmodule : lfd_sticky
